// ---- rtl/arc_regs.sv ----
// reference, calibration and excitation register bank with correction datapath

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - bit 4 of reference config turns internal reference on; resets off.
// - bits 3:2 pick positive reference source; resets to analog supply (01).
// - bits 1:0 pick negative reference source; resets to analog ground (01).
// - three byte registers form a 24-bit offset word, read/write, reset zero.
// - offset word is signed two's complement.
// - offset is subtracted first, gain scaling applied afterwards.
// - three byte registers form unsigned 24-bit gain word, reset 400000h.
// - corrected data is multiplied by gain word over 400000h.
// - source two routing at bits 7:4: 1000 pin one, 1001 pin two, reset 1111.
// - source one routing at bits 3:0: 1000 pin one, 1001 pin two, reset 1111.
// - source two magnitude at bits 7:4: codes 0..9 select off to 2500 uA.
// - source one magnitude at bits 3:0 uses same encoding, resets to off.
module arc_regs
    import arc_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    input  wire logic        ce_i,
    input  wire logic [7:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic      [31:0] readdata_o,
    output logic      [1:0]  response_o,
    output logic             waitrequest_o,
    input  wire logic [23:0] raw_data_i,
    input  wire logic        raw_valid_i,
    output logic      [23:0] corrected_data_o,
    output logic             corrected_valid_o,
    output logic             internal_ref_on_o,
    output logic      [1:0]  pos_ref_select_o,
    output logic      [1:0]  neg_ref_select_o,
    output logic             source_one_pin_one_o,
    output logic             source_one_pin_two_o,
    output logic             source_two_pin_one_o,
    output logic             source_two_pin_two_o,
    output logic      [11:0] source_one_ua_o,
    output logic      [11:0] source_two_ua_o
);

    ////////////////////////////////////////////////////////////////////////////
    // register storage
    logic [23:0] offset_correction_word;
    logic [23:0] gain_correction_word;
    logic [3:0]  source_two_routing;
    logic [3:0]  source_one_routing;
    logic [3:0]  source_two_magnitude;
    logic [3:0]  source_one_magnitude;
    arc_bus_t    bus_state;

    logic        access;
    logic        wr_lane;
    logic        mapped;
    logic [5:0]  idx;
    logic [7:0]  rd_byte;

    assign idx     = address_i[7:2];
    assign access  = ce_i && (bus_state == ARC_BUS_ACK);
    assign wr_lane = access && write_i && byteenable_i[0];

    ////////////////////////////////////////////////////////////////////////////
    // address decode and read mux
    always_comb begin
        mapped  = 1'b1;
        rd_byte = 8'h00;
        if (address_i[1:0] != 2'b00) begin
            mapped = 1'b0;
        end else if (idx == IDX_REF_CFG) begin
            rd_byte = {3'b000, internal_ref_on_o, pos_ref_select_o, neg_ref_select_o};
        end else if (idx == IDX_OFS_LOW) begin
            rd_byte = offset_correction_word[7:0];
        end else if (idx == IDX_OFS_MID) begin
            rd_byte = offset_correction_word[15:8];
        end else if (idx == IDX_OFS_HIGH) begin
            rd_byte = offset_correction_word[23:16];
        end else if (idx == IDX_GAIN_LOW) begin
            rd_byte = gain_correction_word[7:0];
        end else if (idx == IDX_GAIN_MID) begin
            rd_byte = gain_correction_word[15:8];
        end else if (idx == IDX_GAIN_HI) begin
            rd_byte = gain_correction_word[23:16];
        end else if (idx == IDX_ROUTING) begin
            rd_byte = {source_two_routing, source_one_routing};
        end else if (idx == IDX_MAGNITUDE) begin
            rd_byte = {source_two_magnitude, source_one_magnitude};
        end else if (idx == IDX_RESERVED) begin
            rd_byte = 8'h00;
        end else begin
            mapped = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, then answer for one cycle
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_state     <= ARC_BUS_IDLE;
            waitrequest_o <= 1'b1;
            readdata_o    <= 32'h0000_0000;
            response_o    <= RESP_OKAY;
        end else if (ce_i) begin
            case (bus_state)
                ARC_BUS_IDLE: begin
                    if (read_i || write_i) begin
                        bus_state     <= ARC_BUS_ACK;
                        waitrequest_o <= 1'b0;
                        readdata_o    <= {24'h00_0000, rd_byte};
                        response_o    <= mapped ? RESP_OKAY : RESP_DECODE;
                    end
                end
                ARC_BUS_ACK: begin
                    bus_state     <= ARC_BUS_IDLE;
                    waitrequest_o <= 1'b1;
                end
                default: begin
                    bus_state     <= ARC_BUS_IDLE;
                    waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reference configuration; reserved bits are not stored and read as zero
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            internal_ref_on_o <= RST_REF_CFG[REF_ON_BIT];
            pos_ref_select_o  <= RST_REF_CFG[POS_SEL_LSB +: 2];
            neg_ref_select_o  <= RST_REF_CFG[NEG_SEL_LSB +: 2];
        end else if (wr_lane && address_i[1:0] == 2'b00 && idx == IDX_REF_CFG) begin
            internal_ref_on_o <= writedata_i[REF_ON_BIT];
            pos_ref_select_o  <= writedata_i[POS_SEL_LSB +: 2];
            neg_ref_select_o  <= writedata_i[NEG_SEL_LSB +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // calibration words, one byte per register
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            offset_correction_word <= RST_OFFSET;
            gain_correction_word   <= RST_GAIN;
        end else if (wr_lane && address_i[1:0] == 2'b00) begin
            // offset bytes, low address holds low byte
            if (idx == IDX_OFS_LOW) begin
                offset_correction_word[7:0] <= writedata_i[7:0];
            end else if (idx == IDX_OFS_MID) begin
                offset_correction_word[15:8] <= writedata_i[7:0];
            end else if (idx == IDX_OFS_HIGH) begin
                offset_correction_word[23:16] <= writedata_i[7:0];
            end else if (idx == IDX_GAIN_LOW) begin
                gain_correction_word[7:0] <= writedata_i[7:0];
            end else if (idx == IDX_GAIN_MID) begin
                gain_correction_word[15:8] <= writedata_i[7:0];
            end else if (idx == IDX_GAIN_HI) begin
                gain_correction_word[23:16] <= writedata_i[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // excitation source fields
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            source_two_routing   <= RST_ROUTING[SRC_TWO_LSB +: 4];
            source_one_routing   <= RST_ROUTING[SRC_ONE_LSB +: 4];
            source_two_magnitude <= RST_MAGNITUDE[SRC_TWO_LSB +: 4];
            source_one_magnitude <= RST_MAGNITUDE[SRC_ONE_LSB +: 4];
        end else if (wr_lane && address_i[1:0] == 2'b00) begin
            if (idx == IDX_ROUTING) begin
                source_two_routing <= writedata_i[SRC_TWO_LSB +: 4];
                source_one_routing <= writedata_i[SRC_ONE_LSB +: 4];
            end else if (idx == IDX_MAGNITUDE) begin
                source_two_magnitude <= writedata_i[SRC_TWO_LSB +: 4];
                source_one_magnitude <= writedata_i[SRC_ONE_LSB +: 4];
            end
        end
    end

    function automatic logic [11:0] mag_to_ua(input logic [3:0] code);
        logic [11:0] ua;
        case (code)
            4'h0: ua = MAG_UA_0;
            4'h1: ua = MAG_UA_1;
            4'h2: ua = MAG_UA_2;
            4'h3: ua = MAG_UA_3;
            4'h4: ua = MAG_UA_4;
            4'h5: ua = MAG_UA_5;
            4'h6: ua = MAG_UA_6;
            4'h7: ua = MAG_UA_7;
            4'h8: ua = MAG_UA_8;
            4'h9: ua = MAG_UA_9;
            default: ua = MAG_UA_0;
        endcase
        return ua;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // decoded excitation controls, registered so outputs come from flops
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            source_one_pin_one_o <= 1'b0;
            source_one_pin_two_o <= 1'b0;
            source_two_pin_one_o <= 1'b0;
            source_two_pin_two_o <= 1'b0;
            source_one_ua_o      <= MAG_UA_0;
            source_two_ua_o      <= MAG_UA_0;
        end else if (ce_i) begin
            // source two and source one routing, other codes leave a source open
            source_two_pin_one_o <= (source_two_routing == ROUTE_PIN_ONE);
            source_two_pin_two_o <= (source_two_routing == ROUTE_PIN_TWO);
            source_one_pin_one_o <= (source_one_routing == ROUTE_PIN_ONE);
            source_one_pin_two_o <= (source_one_routing == ROUTE_PIN_TWO);
            source_two_ua_o      <= mag_to_ua(source_two_magnitude);
            source_one_ua_o      <= mag_to_ua(source_one_magnitude);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // correction datapath: subtract, then scale and saturate
    logic signed [24:0] diff_q;
    logic               diff_valid;
    logic signed [49:0] product;
    logic signed [27:0] scaled;
    logic        [23:0] next_corrected;

    assign product = diff_q * $signed({1'b0, gain_correction_word});
    assign scaled  = product[GAIN_SHIFT +: 28];

    // clipping keeps a large gain from wrapping a full-scale input
    always_comb begin
        if (scaled > 28'sh07f_ffff) begin
            next_corrected = 24'h7f_ffff;
        end else if (scaled < -28'sh080_0000) begin
            next_corrected = 24'h80_0000;
        end else begin
            next_corrected = scaled[23:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            diff_q            <= 25'sh000_0000;
            diff_valid        <= 1'b0;
            corrected_data_o  <= 24'h00_0000;
            corrected_valid_o <= 1'b0;
        end else if (ce_i) begin
            diff_valid        <= raw_valid_i;
            corrected_valid_o <= diff_valid;
            // signed offset, offset removed before scaling
            if (raw_valid_i) begin
                diff_q <= $signed({raw_data_i[23], raw_data_i})
                        - $signed({offset_correction_word[23], offset_correction_word});
            end
            // scale by gain word over 400000h
            if (diff_valid) begin
                corrected_data_o <= next_corrected;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    a_wait_one_cycle: assert property ((read_i || write_i) && waitrequest_o && ce_i
        |=> !waitrequest_o) else $error("request not answered after one wait cycle");
    a_answer_once: assert property (!waitrequest_o && ce_i |=> waitrequest_o)
        else $error("waitrequest held low more than one cycle");
    a_upper_zero: assert property (!waitrequest_o |-> readdata_o[31:8] == 24'h00_0000)
        else $error("unused read bits not zero");
    a_unmapped_resp: assert property (waitrequest_o && ce_i && read_i
        && address_i[7:2] == 6'h10 |=> response_o == RESP_DECODE && readdata_o == 32'h0)
        else $error("unmapped read not flagged");
    a_ref_enable: assert property (wr_lane && address_i == 8'h18
        |=> internal_ref_on_o == $past(writedata_i[4])) else $error("reference enable lost");
    a_pos_select: assert property (wr_lane && address_i == 8'h18
        |=> pos_ref_select_o == $past(writedata_i[3:2])) else $error("pos select lost");
    a_neg_select: assert property (wr_lane && address_i == 8'h18
        |=> neg_ref_select_o == $past(writedata_i[1:0])) else $error("neg select lost");
    a_offset_high: assert property (wr_lane && address_i == 8'h24
        |=> offset_correction_word[23:16] == $past(writedata_i[7:0]))
        else $error("offset high byte lost");
    a_offset_low: assert property (wr_lane && address_i == 8'h1c
        |=> offset_correction_word[7:0] == $past(writedata_i[7:0]))
        else $error("offset low byte lost");
    a_gain_low: assert property (wr_lane && address_i == 8'h28
        |=> gain_correction_word[7:0] == $past(writedata_i[7:0]))
        else $error("gain low byte lost");
    a_gain_high: assert property (wr_lane && address_i == 8'h30
        |=> gain_correction_word[23:16] == $past(writedata_i[7:0]))
        else $error("gain high byte lost");
    a_unity_gain: assert property (diff_valid && ce_i && gain_correction_word == RST_GAIN
        |=> corrected_data_o == $past(diff_q[23:0]) || $past(diff_q[24] != diff_q[23]))
        else $error("unity gain altered data");
    a_result_timing: assert property (raw_valid_i && ce_i ##1 ce_i |=> corrected_valid_o)
        else $error("result not after two cycles");
    a_route_one: assert property (ce_i |=> source_one_pin_one_o
        == ($past(source_one_routing) == 4'h8)) else $error("source one route wrong");
    a_route_two: assert property (ce_i |=> source_two_pin_two_o
        == ($past(source_two_routing) == 4'h9)) else $error("source two route wrong");
    a_mag_top: assert property (ce_i && source_two_magnitude == 4'h9
        |=> source_two_ua_o == 12'h9c4) else $error("source two 2500 uA wrong");
    a_mag_off: assert property (ce_i && source_one_magnitude == 4'h0
        |=> source_one_ua_o == 12'h000) else $error("source one off wrong");
    a_mag_mid: assert property (ce_i && source_one_magnitude == 4'h5
        |=> source_one_ua_o == 12'h2ee) else $error("source one 750 uA wrong");
    // a write without the low lane must not touch the reference enable or positive select
    a_lane_refused: assert property (access && write_i && !byteenable_i[0]
        |=> $stable(internal_ref_on_o) && $stable(pos_ref_select_o))
        else $error("write without lane took effect");

    c_write_done: cover property (write_i && !waitrequest_o);
    c_read_done: cover property (read_i && !waitrequest_o);
    c_result: cover property (corrected_valid_o);
    c_pin_one: cover property (source_one_pin_one_o);
    c_saturate: cover property (diff_valid && ce_i && scaled > 28'sh07f_ffff);

endmodule

// ---- rtl/arc_pkg.sv ----
// constants for the reference and calibration register bank
package arc_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_REF_CFG  = 6'h06;
    localparam logic [5:0] IDX_OFS_LOW  = 6'h07;
    localparam logic [5:0] IDX_OFS_MID  = 6'h08;
    localparam logic [5:0] IDX_OFS_HIGH = 6'h09;
    localparam logic [5:0] IDX_GAIN_LOW = 6'h0a;
    localparam logic [5:0] IDX_GAIN_MID = 6'h0b;
    localparam logic [5:0] IDX_GAIN_HI  = 6'h0c;
    localparam logic [5:0] IDX_ROUTING  = 6'h0d;
    localparam logic [5:0] IDX_MAGNITUDE = 6'h0e;
    localparam logic [5:0] IDX_RESERVED = 6'h0f;

    // reset values
    localparam logic [7:0]  RST_REF_CFG   = 8'h05;
    localparam logic [23:0] RST_OFFSET    = 24'h00_0000;
    localparam logic [23:0] RST_GAIN      = 24'h40_0000;
    localparam logic [7:0]  RST_ROUTING   = 8'hff;
    localparam logic [7:0]  RST_MAGNITUDE = 8'h00;

    // field positions
    localparam int REF_ON_BIT   = 4;
    localparam int POS_SEL_LSB  = 2;
    localparam int NEG_SEL_LSB  = 0;
    localparam int SRC_TWO_LSB  = 4;
    localparam int SRC_ONE_LSB  = 0;

    // routing codes
    localparam logic [3:0] ROUTE_PIN_ONE = 4'h8;
    localparam logic [3:0] ROUTE_PIN_TWO = 4'h9;

    // gain word is scaled by 2^22, so 400000h is unity
    localparam int GAIN_SHIFT = 22;

    // avalon response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECODE = 2'h3;

    // magnitude codes 0000..1001 in microamps; others read as off
    localparam logic [11:0] MAG_UA_0 = 12'h000;
    localparam logic [11:0] MAG_UA_1 = 12'h032;
    localparam logic [11:0] MAG_UA_2 = 12'h064;
    localparam logic [11:0] MAG_UA_3 = 12'h0fa;
    localparam logic [11:0] MAG_UA_4 = 12'h1f4;
    localparam logic [11:0] MAG_UA_5 = 12'h2ee;
    localparam logic [11:0] MAG_UA_6 = 12'h3e8;
    localparam logic [11:0] MAG_UA_7 = 12'h5dc;
    localparam logic [11:0] MAG_UA_8 = 12'h7d0;
    localparam logic [11:0] MAG_UA_9 = 12'h9c4;

    typedef enum logic [0:0] {
        ARC_BUS_IDLE = 1'b0,
        ARC_BUS_ACK  = 1'b1
    } arc_bus_t;

endpackage

// ---- testbench/arc_regs_tb.sv ----
// self-checking testbench for the reference and calibration register bank
module arc_regs_tb
    import arc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_sys_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        ce_i = 1'b1;
    logic [7:0]  address_i = 8'h00;
    logic        read_i = 1'b0;
    logic        write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0000_0000;
    logic [3:0]  byteenable_i = 4'h0;
    logic [31:0] readdata_o;
    logic [1:0]  response_o;
    logic        waitrequest_o;
    logic [23:0] raw_data_i = 24'h00_0000;
    logic        raw_valid_i = 1'b0;
    logic [23:0] corrected_data_o;
    logic        corrected_valid_o;
    logic        internal_ref_on_o;
    logic [1:0]  pos_ref_select_o;
    logic [1:0]  neg_ref_select_o;
    logic        s1p1, s1p2, s2p1, s2p2;
    logic [11:0] source_one_ua_o;
    logic [11:0] source_two_ua_o;
    int          n_errors = 0;
    int          total_checks = 0;
    logic [31:0] seed = 32'h0000_005f;

    arc_regs i_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
        .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .byteenable_i(byteenable_i), .readdata_o(readdata_o), .response_o(response_o),
        .waitrequest_o(waitrequest_o), .raw_data_i(raw_data_i), .raw_valid_i(raw_valid_i),
        .corrected_data_o(corrected_data_o), .corrected_valid_o(corrected_valid_o),
        .internal_ref_on_o(internal_ref_on_o), .pos_ref_select_o(pos_ref_select_o),
        .neg_ref_select_o(neg_ref_select_o), .source_one_pin_one_o(s1p1),
        .source_one_pin_two_o(s1p2), .source_two_pin_one_o(s2p1), .source_two_pin_two_o(s2p2),
        .source_one_ua_o(source_one_ua_o), .source_two_ua_o(source_two_ua_o));

    always #50 clk_sys_i = ~clk_sys_i;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // signed difference first, then unsigned gain over 2^22, clipped to 24 bits
    function automatic logic [23:0] corr(logic [23:0] raw, logic [23:0] off, logic [23:0] g);
        longint p;
        p = ((longint'($signed(raw)) - longint'($signed(off))) * longint'(g)) >>> 22;
        if (p > longint'(24'h7f_ffff)) return 24'h7f_ffff;
        if (p < -longint'(24'h80_0000)) return 24'h80_0000;
        return p[23:0];
    endfunction

    function automatic logic [1:0] pins(logic [3:0] c);
        return (c == 4'h8) ? 2'h1 : ((c == 4'h9) ? 2'h2 : 2'h0);
    endfunction

    function automatic logic [11:0] ua(logic [3:0] c);
        case (c)
            4'h1: return 12'h032;
            4'h2: return 12'h064;
            4'h3: return 12'h0fa;
            4'h4: return 12'h1f4;
            4'h5: return 12'h2ee;
            4'h6: return 12'h3e8;
            4'h7: return 12'h5dc;
            4'h8: return 12'h7d0;
            4'h9: return 12'h9c4;
            default: return 12'h000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until the rising edge at which waitrequest is sampled low
    task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] wd,
                       input logic [3:0] be, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        read_i <= rd;
        write_i <= !rd;
        address_i <= a;
        writedata_i <= {24'h00_0000, wd};
        byteenable_i <= be;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (waitrequest_o !== 1'b0 && n < 20);
        if (n >= 20) chk(32'(waitrequest_o), 32'h0000_0000);
        d = readdata_o;
        r = response_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] v);
        logic [31:0] d;
        logic [1:0]  r;
        bus(1'b0, {idx, 2'b00}, v, 4'hf, d, r);
        chk(32'(r), 32'(RESP_OKAY));
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        bus(1'b1, a, 8'h00, 4'hf, d, r);
        chk(d, {24'h00_0000, v});
        chk(32'(r), 32'(er));
    endtask

    // raw sample taken at the next edge, result expected one edge later, seen at the second falling edge
    task automatic dp(input logic [23:0] raw, input logic [23:0] exp);
        int n;
        n = 0;
        raw_data_i <= raw;
        raw_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        raw_valid_i <= 1'b0;
        raw_data_i <= ~raw;
        do begin
            @(negedge clk_sys_i);
            n++;
        end while (corrected_valid_o !== 1'b1 && n < 10);
        chk(32'(n), 32'h0000_0002);
        chk(32'(corrected_data_o), 32'(exp));
        @(posedge clk_sys_i);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        $display("watchdog expired at %0t", $time);
        results();
    end

    initial begin
        logic [7:0]  rst_tab [16];
        logic [23:0] off, g, raw;
        logic [31:0] x;
        rst_tab = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00,
                    8'h00, 8'h00, 8'h40, 8'hff, 8'h00, 8'h00};
        repeat (3) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        @(posedge clk_sys_i);
        // reset values of every register and the decoded outputs
        chk({27'h0, internal_ref_on_o, pos_ref_select_o, neg_ref_select_o}, 32'h0000_0005);
        chk({28'h0, s2p2, s2p1, s1p2, s1p1}, 32'h0000_0000);
        chk({8'h00, source_two_ua_o, source_one_ua_o}, 32'h0000_0000);
        for (int i = 6; i < 16; i++) rd({i[5:0], 2'b00}, rst_tab[i], RESP_OKAY);
        x = xs();
        dp(x[23:0], x[23:0]);
        $display("reset values done");
        // every reserved-bit-clear value of reference config
        for (int c = 0; c < 32; c++) begin
            wr(IDX_REF_CFG, 8'(c));
            rd({IDX_REF_CFG, 2'b00}, 8'(c), RESP_OKAY);
            chk({27'h0, internal_ref_on_o, pos_ref_select_o, neg_ref_select_o}, 32'(c));
        end
        $display("reference config done");
        // all routing and magnitude codes in both nibbles
        for (int c = 0; c < 16; c++) begin
            wr(IDX_ROUTING, {c[3:0], ~c[3:0]});
            wr(IDX_MAGNITUDE, {c[3:0], ~c[3:0]});
            // decoded outputs trail the register by one edge
            @(posedge clk_sys_i);
            chk({28'h0, s2p2, s2p1, s1p2, s1p1}, {28'h0, pins(c[3:0]), pins(~c[3:0])});
            chk(32'(source_two_ua_o), 32'(ua(c[3:0])));
            chk(32'(source_one_ua_o), 32'(ua(~c[3:0])));
        end
        $display("excitation codes done");
        // refused accesses leave state; unmapped and misaligned ones answer decode error
        bus(1'b0, {IDX_REF_CFG, 2'b00}, 8'h1a, 4'he, x, off[1:0]);
        chk(32'(off[1:0]), 32'(RESP_OKAY));
        bus(1'b0, 8'h40, 8'h55, 4'hf, x, off[1:0]);
        chk(32'(off[1:0]), 32'(RESP_DECODE));
        rd({IDX_REF_CFG, 2'b00}, 8'h1f, RESP_OKAY);
        wr(IDX_RESERVED, 8'hff);
        rd({IDX_RESERVED, 2'b00}, 8'h00, RESP_OKAY);
        rd(8'h14, 8'h00, RESP_DECODE);
        rd(8'h40, 8'h00, RESP_DECODE);
        rd(8'h19, 8'h00, RESP_DECODE);
        $display("refused accesses done");
        // calibration words with random and extreme values
        for (int i = 0; i < 6; i++) begin
            x = xs();
            off = (i == 0) ? 24'h80_0000 : x[23:0];
            x = xs();
            g = (i == 1) ? 24'hff_ffff : x[23:0];
            for (int b = 0; b < 3; b++) begin
                wr(6'(IDX_OFS_LOW + b), off[8*b+:8]);
                wr(6'(IDX_GAIN_LOW + b), g[8*b+:8]);
            end
            for (int b = 0; b < 3; b++) begin
                rd({6'(IDX_OFS_LOW + b), 2'b00}, off[8*b+:8], RESP_OKAY);
                rd({6'(IDX_GAIN_LOW + b), 2'b00}, g[8*b+:8], RESP_OKAY);
            end
            x = xs();
            raw = (i == 0) ? 24'h7f_ffff : x[23:0];
            dp(raw, corr(raw, off, g));
            x = xs();
            dp(x[23:0], corr(x[23:0], off, g));
        end
        $display("calibration datapath done");
        // a frozen block must ignore a raw sample
        ce_i <= 1'b0;
        raw_valid_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        chk(32'(corrected_valid_o), 32'h0000_0000);
        raw_valid_i <= 1'b0;
        ce_i <= 1'b1;
        @(posedge clk_sys_i);
        $display("clock enable done");
        results();
    end
endmodule
